// ### core/smp_pkg.sv
package smp_pkg;

  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_SUM_LSB = 8'h09;
  localparam logic [7:0] OFF_SUM_MSB = 8'h0A;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // Control register field positions
  localparam int CTRL_INDEX_LSB = 4;
  localparam int CTRL_PEND_BIT = 3;
  localparam int CTRL_EN_BIT = 2;
  localparam int CTRL_ACT_BIT = 1;
  localparam int CTRL_INV_BIT = 0;

  // Status register field positions
  localparam int STAT_HIT_BIT = 0;
  localparam int STAT_SEL_VALID_BIT = 1;
  localparam int STAT_COUNT_LSB = 3;

  // Table geometry
  localparam int TABLE_DEPTH = 16;
  localparam int INDEX_W = 4;
  localparam int SUM_W = 16;
  localparam int COUNT_W = 5;

  // Reset values
  localparam logic [3:0] INDEX_RESET = 4'h0;
  localparam logic PEND_RESET = 1'b0;
  localparam logic EN_RESET = 1'b0;
  localparam logic [15:0] SUM_RESET = 16'h0000;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Data request packet seen by the receiver, with its source checksum
  typedef struct packed {
    logic valid;
    logic [SUM_W-1:0] checksum;
  } smp_req_t;

  // Software-held control fields
  typedef struct packed {
    logic [INDEX_W-1:0] index;
    logic sw_pend;
    logic enable;
  } smp_ctrl_t;

  // One-cycle table commands decoded from register writes
  typedef struct packed {
    logic wr_lo;
    logic wr_hi;
    logic activate;
    logic invalidate;
    logic [7:0] data;
  } smp_cmd_t;

  // Lookup outcome
  typedef struct packed {
    logic done;
    logic hit;
    logic [INDEX_W-1:0] idx;
  } smp_result_t;

endpackage : smp_pkg

// ### core/smp_table.sv
module smp_table #(
  parameter int DEPTH = smp_pkg::TABLE_DEPTH,
  parameter int IDX_W = smp_pkg::INDEX_W,
  parameter int SUM_W = smp_pkg::SUM_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [IDX_W-1:0] sel_index_i,
  input wire smp_pkg::smp_cmd_t cmd_i,
  input wire smp_pkg::smp_req_t req_i,
  output logic [SUM_W-1:0] sel_sum_o,
  output logic [DEPTH-1:0] valid_o,
  output logic hit_o,
  output logic [IDX_W-1:0] hit_idx_o
);

  logic [SUM_W-1:0] sum_q [DEPTH];
  logic [SUM_W-1:0] sum_d [DEPTH];
  logic [DEPTH-1:0] valid_q;
  logic [DEPTH-1:0] valid_d;

  // Byte writes and valid flag changes touch only the selected entry
  always_comb begin
    valid_d = valid_q;
    for (int i = 0; i < DEPTH; i++) begin
      sum_d[i] = sum_q[i];
    end
    if (cmd_i.wr_lo) begin
      sum_d[sel_index_i][7:0] = cmd_i.data;
    end
    if (cmd_i.wr_hi) begin
      sum_d[sel_index_i][SUM_W-1:8] = cmd_i.data;
    end
    if (cmd_i.activate) begin
      valid_d[sel_index_i] = 1'b1; // see (R5)
    end
    // Invalidate wins when both are written, so a stale entry never matches
    if (cmd_i.invalidate) begin
      valid_d[sel_index_i] = 1'b0; // see (R8)
    end
  end

  // Table storage; valid flags clear at reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_q <= '0; // see (R13)
      for (int i = 0; i < DEPTH; i++) begin
        sum_q[i] <= smp_pkg::SUM_RESET;
      end
    end else begin
      valid_q <= valid_d;
      for (int i = 0; i < DEPTH; i++) begin
        sum_q[i] <= sum_d[i];
      end
    end
  end

  // Compare only valid entries; lowest matching index reported
  always_comb begin
    hit_o = 1'b0;
    hit_idx_o = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (valid_q[i] && (sum_q[i] == req_i.checksum)) begin // see (R6) see (R9)
        hit_o = req_i.valid;
        hit_idx_o = IDX_W'(i);
      end
    end
  end

  assign sel_sum_o = sum_q[sel_index_i]; // see (R12)
  assign valid_o = valid_q;

endmodule : smp_table

// ### core/smp_ctrl.sv
// Overview of operation
// (R1) Control bits 7..4 hold the index selecting one table entry.
// (R2) Matching off: acknowledge pending bit copies the software pending bit.
// (R3) Matching on: pending bit comes from table lookup, software bit ignored.
// (R4) Control bit 2 enables source address matching.
// (R5) Writing one to bit 1 marks the selected entry valid.
// (R6) Valid entries are compared on each received data request packet.
// (R7) Bit 1 is write-only, self-clearing; zero does nothing; reads zero.
// (R8) Writing one to bit 0 marks the selected entry invalid.
// (R9) Invalid entries are not compared against data requests.
// (R10) Bit 0 is write-only, self-clearing; zero does nothing; reads zero.
// (R11) Software selects index, writes both checksum bytes, then activates.
// (R12) Checksum reads return the selected entry's 16-bit value.
// (R13) Sixteen entries with checksum and valid flag; flags cleared at reset.
//
// Decided for this implementation: the strobed register port.
module smp_ctrl #(
  parameter int DEPTH = smp_pkg::TABLE_DEPTH,
  parameter int IDX_W = smp_pkg::INDEX_W,
  parameter int SUM_W = smp_pkg::SUM_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [smp_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [smp_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [smp_pkg::DATA_W-1:0] reg_rdata_o,
  // Received data request packets from the receive path
  input wire smp_pkg::smp_req_t req_i,
  // Frame pending bit for the next auto-sent acknowledge
  output logic ack_pending_o,
  // Lookup result of the most recent data request received while matching is enabled
  output logic lookup_done_o,
  output logic lookup_hit_o,
  output logic [IDX_W-1:0] lookup_idx_o,
  // Match enable control field and valid entry count, mirrored for the rest of the modem
  output logic src_match_enable_o,
  output logic [smp_pkg::COUNT_W-1:0] active_count_o
);

  // Register decode
  logic sel_ctrl;
  logic sel_lsb;
  logic sel_msb;
  logic sel_status;

  // Control state
  smp_pkg::smp_ctrl_t ctrl_q;
  smp_pkg::smp_ctrl_t ctrl_d;

  // Table command pulses for this cycle
  smp_pkg::smp_cmd_t cmd;

  // Table outputs
  logic [SUM_W-1:0] sel_sum;
  logic [DEPTH-1:0] valid_vec;
  logic tbl_hit;
  logic [IDX_W-1:0] tbl_hit_idx;

  // Lookup and acknowledge state
  smp_pkg::smp_result_t res_q;
  smp_pkg::smp_result_t res_d;
  logic last_hit_q;
  logic last_hit_d;
  logic pend_q;
  logic pend_d;

  // Readback state
  logic [smp_pkg::DATA_W-1:0] rdata_q;
  logic [smp_pkg::DATA_W-1:0] rdata_d;
  logic [smp_pkg::COUNT_W-1:0] count_q;
  logic [smp_pkg::COUNT_W-1:0] count_d;

  // Address decoding
  always_comb begin
    sel_ctrl = 1'b0;
    sel_lsb = 1'b0;
    sel_msb = 1'b0;
    sel_status = 1'b0;
    if (reg_addr_i == smp_pkg::OFF_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (reg_addr_i == smp_pkg::OFF_SUM_LSB) begin
      sel_lsb = 1'b1;
    end else if (reg_addr_i == smp_pkg::OFF_SUM_MSB) begin
      sel_msb = 1'b1;
    end else if (reg_addr_i == smp_pkg::OFF_STATUS) begin
      sel_status = 1'b1;
    end
  end

  // Control register next value; bits 1 and 0 are never stored
  always_comb begin
    ctrl_d = ctrl_q;
    if (reg_wr_i && sel_ctrl) begin
      ctrl_d.index = reg_wdata_i[smp_pkg::CTRL_INDEX_LSB +: IDX_W]; // see (R1)
      ctrl_d.sw_pend = reg_wdata_i[smp_pkg::CTRL_PEND_BIT];
      ctrl_d.enable = reg_wdata_i[smp_pkg::CTRL_EN_BIT]; // see (R4)
    end
  end

  // Control register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q.index <= smp_pkg::INDEX_RESET;
      ctrl_q.sw_pend <= smp_pkg::PEND_RESET;
      ctrl_q.enable <= smp_pkg::EN_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Table commands act on the index already held, not the one in the
  // same write; software must select the index in an earlier write
  always_comb begin
    cmd.wr_lo = reg_wr_i && sel_lsb;
    cmd.wr_hi = reg_wr_i && sel_msb;
    cmd.activate = reg_wr_i && sel_ctrl && reg_wdata_i[smp_pkg::CTRL_ACT_BIT]; // see (R5) (R7)
    cmd.invalidate = reg_wr_i && sel_ctrl && reg_wdata_i[smp_pkg::CTRL_INV_BIT]; // see (R8) (R10)
    cmd.data = reg_wdata_i;
  end

  // Source address table with its comparators
  smp_table #(
    .DEPTH(DEPTH),
    .IDX_W(IDX_W),
    .SUM_W(SUM_W)
  ) u_table (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sel_index_i(ctrl_q.index),
    .cmd_i(cmd),
    .req_i(req_i),
    .sel_sum_o(sel_sum),
    .valid_o(valid_vec),
    .hit_o(tbl_hit),
    .hit_idx_o(tbl_hit_idx)
  );

  // Lookup result; a lookup runs only while matching is enabled
  always_comb begin
    res_d.done = 1'b0;
    res_d.hit = res_q.hit;
    res_d.idx = res_q.idx;
    last_hit_d = last_hit_q;
    if (req_i.valid && ctrl_q.enable) begin
      res_d.done = 1'b1; // see (R6)
      res_d.hit = tbl_hit;
      res_d.idx = tbl_hit_idx;
      last_hit_d = tbl_hit;
    end
  end

  // Frame pending source: software bit or lookup outcome. The new lookup
  // feeds the bit in the same edge so an acknowledge never sees a stale hit
  always_comb begin
    if (ctrl_q.enable) begin
      pend_d = last_hit_d; // see (R3)
    end else begin
      pend_d = ctrl_q.sw_pend; // see (R2)
    end
  end

  // Lookup and acknowledge registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_q <= '0;
      last_hit_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      res_q <= res_d;
      last_hit_q <= last_hit_d;
      pend_q <= pend_d;
    end
  end

  // Number of valid entries, shown in the status register
  always_comb begin
    count_d = '0;
    for (int i = 0; i < DEPTH; i++) begin
      count_d = count_d + smp_pkg::COUNT_W'(valid_vec[i]);
    end
  end

  // Count register, lags the table by one cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads
  // return zero. Self-clearing bits 1 and 0 always read as zero
  always_comb begin
    rdata_d = smp_pkg::RDATA_RESET;
    if (reg_rd_i) begin
      if (sel_ctrl) begin
        rdata_d[smp_pkg::CTRL_INDEX_LSB +: IDX_W] = ctrl_q.index; // see (R1)
        rdata_d[smp_pkg::CTRL_PEND_BIT] = ctrl_q.sw_pend;
        rdata_d[smp_pkg::CTRL_EN_BIT] = ctrl_q.enable; // see (R7) (R10)
      end else if (sel_lsb) begin
        rdata_d = sel_sum[7:0]; // see (R12)
      end else if (sel_msb) begin
        rdata_d = sel_sum[SUM_W-1:8]; // see (R12)
      end else if (sel_status) begin
        rdata_d[smp_pkg::STAT_HIT_BIT] = last_hit_q;
        rdata_d[smp_pkg::STAT_SEL_VALID_BIT] = valid_vec[ctrl_q.index];
        rdata_d[smp_pkg::STAT_COUNT_LSB +: smp_pkg::COUNT_W] = count_q;
      end
    end
  end

  // Read data register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= smp_pkg::RDATA_RESET;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata_o = rdata_q;
  assign ack_pending_o = pend_q;
  assign lookup_done_o = res_q.done;
  assign lookup_hit_o = res_q.hit;
  assign lookup_idx_o = res_q.idx;
  assign src_match_enable_o = ctrl_q.enable;
  assign active_count_o = count_q;

endmodule : smp_ctrl

// ### test/smp_ctrl_properties.sv
module smp_ctrl_properties #(
  parameter int DEPTH = smp_pkg::TABLE_DEPTH,
  parameter int IDX_W = smp_pkg::INDEX_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [smp_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [smp_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [smp_pkg::DATA_W-1:0] reg_rdata_o,
  input wire smp_pkg::smp_req_t req_i,
  input wire logic ack_pending_o,
  input wire logic lookup_done_o,
  input wire logic lookup_hit_o,
  input wire logic [IDX_W-1:0] lookup_idx_o,
  input wire logic src_match_enable_o,
  input wire logic [smp_pkg::COUNT_W-1:0] active_count_o
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // Control register accesses
  sequence s_ctrl_wr;
    reg_wr_i && reg_addr_i == smp_pkg::OFF_CTRL;
  endsequence
  sequence s_ctrl_rd;
    reg_rd_i && reg_addr_i == smp_pkg::OFF_CTRL;
  endsequence
  a_cmd_bits_zero: assert property (s_ctrl_rd |=> reg_rdata_o[1:0] == 2'h0)
    else $error("command bits read back nonzero");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_enable_mirror: assert property (s_ctrl_wr |=>
    src_match_enable_o == $past(reg_wdata_i[smp_pkg::CTRL_EN_BIT]))
    else $error("enable does not follow control write");
  // Pending register samples the stored control bits, so it trails the write by two edges
  a_sw_pend_copy: assert property (s_ctrl_wr ##1 !src_match_enable_o |=>
    ack_pending_o == $past(reg_wdata_i[smp_pkg::CTRL_PEND_BIT], 2))
    else $error("pending bit not copied while matching off");
  a_lookup_answer: assert property (req_i.valid && src_match_enable_o |=> lookup_done_o)
    else $error("no lookup for request while enabled");
  a_lookup_cause: assert property (lookup_done_o |-> $past(req_i.valid))
    else $error("lookup without request");
  a_ack_from_hit: assert property (lookup_done_o && src_match_enable_o |->
    ack_pending_o == lookup_hit_o)
    else $error("pending bit differs from lookup hit");
  a_count_cause: assert property ($changed(active_count_o) |-> $past(reg_wr_i, 2))
    else $error("valid count moved without a write");
  a_count_bound: assert property (active_count_o <= DEPTH)
    else $error("valid count above table depth");
  // One write touches one entry, so the count moves by exactly one
  a_count_step: assert property ($changed(active_count_o) |->
    (active_count_o - $past(active_count_o) == 5'h01) ||
    ($past(active_count_o) - active_count_o == 5'h01))
    else $error("valid count jumped by more than one");
endmodule : smp_ctrl_properties

bind smp_ctrl smp_ctrl_properties #(.DEPTH(DEPTH), .IDX_W(IDX_W)) u_props (
  .sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .req_i, .ack_pending_o, .lookup_done_o, .lookup_hit_o, .lookup_idx_o,
  .src_match_enable_o, .active_count_o);

// ### test/smp_remote_node.sv
module smp_remote_node (
  input wire logic sys_clk_i,
  output smp_pkg::smp_req_t req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle lines start at zero and show the inverse checksum after a send, so a stale value never matches by luck
  initial req_o = '0;
  // One data request packet, valid for a single cycle
  task automatic send(input logic [15:0] sum);
    req_o <= '{valid: 1'b1, checksum: sum};
    @(posedge sys_clk_i);
    req_o <= '{valid: 1'b0, checksum: ~sum};
  endtask : send
endmodule : smp_remote_node

// ### test/smp_ctrl_tb.sv
module smp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  smp_pkg::smp_req_t req_i;
  logic ack_pending_o;
  logic lookup_done_o;
  logic lookup_hit_o;
  logic [3:0] lookup_idx_o;
  logic src_match_enable_o;
  logic [4:0] active_count_o;
  logic [15:0] s;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  // 250 MHz clock
  always #2 sys_clk_i = ~sys_clk_i;
  smp_ctrl u_smp_ctrl (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .req_i, .ack_pending_o, .lookup_done_o, .lookup_hit_o,
    .lookup_idx_o, .src_match_enable_o, .active_count_o);
  smp_remote_node u_node (.sys_clk_i, .req_o(req_i));
  // Compare with case inequality so unknowns fail
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // Strobe gap of one cycle keeps each strobe assigned once per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    cmp(reg_rdata_o, exp);
    @(posedge sys_clk_i);
  endtask : rd
  // Packs done, hit, pending and index; index only matters on a hit
  task automatic look(input logic [15:0] sum, input logic [7:0] exp);
    u_node.send(sum);
    @(negedge sys_clk_i);
    cmp({lookup_done_o, lookup_hit_o, ack_pending_o, 1'b0,
      lookup_hit_o ? lookup_idx_o : 4'h0}, exp);
    @(posedge sys_clk_i);
  endtask : look
  // Pending bit trails a control write by two edges, so look after the falling edge;
  // packs pending, enable and valid count
  task automatic chk_out(input logic [7:0] exp);
    @(negedge sys_clk_i);
    cmp({ack_pending_o, 1'b0, src_match_enable_o, active_count_o}, exp);
    @(posedge sys_clk_i);
  endtask : chk_out
  function automatic logic [15:0] sumv(input logic [3:0] i);
    return {4'hA, i, 4'h5, i};
  endfunction : sumv
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(smp_pkg::OFF_CTRL, 8'h00);
    rd(smp_pkg::OFF_STATUS, 8'h00);
    rd(8'h3C, 8'h00);
    $display("reset test done");
    wr(smp_pkg::OFF_CTRL, 8'h08);
    chk_out(8'h80);
    wr(smp_pkg::OFF_CTRL, 8'h00);
    chk_out(8'h00);
    $display("software pending test done");
    // Select, load both bytes high first, then activate
    for (int i = 0; i < 16; i++) begin
      s = sumv(i[3:0]);
      wr(smp_pkg::OFF_CTRL, {i[3:0], 4'h0});
      wr(smp_pkg::OFF_SUM_MSB, s[15:8]);
      wr(smp_pkg::OFF_SUM_LSB, s[7:0]);
      wr(smp_pkg::OFF_CTRL, {i[3:0], 4'h2});
    end
    rd(smp_pkg::OFF_CTRL, 8'hF0);
    rd(smp_pkg::OFF_SUM_LSB, 8'h5F);
    rd(smp_pkg::OFF_SUM_MSB, 8'hAF);
    rd(smp_pkg::OFF_STATUS, 8'h82);
    $display("table load test done");
    wr(smp_pkg::OFF_CTRL, 8'hFC);
    chk_out(8'h30);
    for (int i = 0; i < 16; i++) begin
      look(sumv(i[3:0]), {4'hE, i[3:0]});
    end
    look(16'hFFFF, 8'h80);
    $display("lookup test done");
    wr(smp_pkg::OFF_CTRL, 8'h34);
    wr(smp_pkg::OFF_CTRL, 8'h35);
    chk_out(8'h2F);
    look(sumv(4'h3), 8'h80);
    wr(smp_pkg::OFF_CTRL, 8'h34);
    rd(smp_pkg::OFF_STATUS, 8'h78);
    rd(smp_pkg::OFF_CTRL, 8'h34);
    wr(smp_pkg::OFF_CTRL, 8'h36);
    look(sumv(4'h3), 8'hE3);
    look(16'hFFFF, 8'h80);
    // Activate and invalidate together: invalidate wins
    wr(smp_pkg::OFF_CTRL, 8'h37);
    chk_out(8'h2F);
    look(sumv(4'h3), 8'h80);
    $display("invalidate test done");
    wr(smp_pkg::OFF_CTRL, 8'h38);
    chk_out(8'h8F);
    look(sumv(4'h3), 8'h20);
    $display("disable test done");
    // Reset in mid-run must clear every valid flag and the control fields
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(smp_pkg::OFF_STATUS, 8'h00);
    rd(smp_pkg::OFF_CTRL, 8'h00);
    chk_out(8'h00);
    $display("second reset test done");
    finish_test();
  end
endmodule : smp_ctrl_tb
